// >>> core/startup_profile_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module startup_profile_ctrl
    import startup_profile_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_q,
    input wire logic start_req,
    output logic aligning_q,
    output logic open_loop_q,
    output logic closed_loop_q,
    output logic [39:0] freq_q
);

    // ==========================================================
    // Register
    // ==========================================================
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic [15:0] rdata_d;

    // Writes land only at the profile address; the reserved bit stays 0.
    always_comb begin
        cfg_d = cfg_q;
        rdata_d = reg_rdata_q;
        if (reg_wr && reg_addr == PROFILE_ADDR) begin
            cfg_d = {1'b0, reg_wdata[RSVD_BIT-1:0]};
        end
        if (reg_rd) begin
            rdata_d = (reg_addr == PROFILE_ADDR) ? cfg_q : 16'h0000;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q <= PROFILE_RESET;
            reg_rdata_q <= 16'h0000;
        end else begin
            cfg_q <= cfg_d;
            reg_rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // Field decode
    // ==========================================================
    logic range_slow;
    logic [2:0] coef2;
    logic [2:0] coef1;
    logic [4:0] thr_code;
    logic [2:0] align_code;
    logic [31:0] a2_val;
    logic [31:0] a1_val;
    logic [39:0] thr_val;
    logic [31:0] align_len;

    // Converts a handover code into a frequency in nHz.
    function automatic logic [39:0] thr_nhz(input logic [4:0] c);
        if (!c[4]) begin
            thr_nhz = 40'(40'(c) * THR0_STEP);
        end else begin
            thr_nhz = 40'(40'(c[3:0]) * THR1_STEP) + THR1_BASE;
        end
    endfunction

    assign range_slow = cfg_q[RANGE_BIT];
    assign coef2 = cfg_q[COEF2_LSB +: 3];
    assign coef1 = cfg_q[COEF1_LSB +: 3];
    assign thr_code = cfg_q[THR_LSB +: 5];
    assign align_code = cfg_q[ALIGN_LSB +: 3];

    // The range bit picks one of two tables for each coefficient.
    assign a2_val = range_slow ? ACCEL2_SLOW[coef2] : ACCEL2_FAST[coef2];
    assign a1_val = range_slow ? ACCEL1_SLOW[coef1] : ACCEL1_FAST[coef1];
    assign thr_val = thr_nhz(thr_code);
    assign align_len = ALIGN_TICKS[align_code];

    // ==========================================================
    // Start-up sequencer
    // ==========================================================
    seq_state_t st_q;
    seq_state_t st_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [31:0] accel_q;
    logic [31:0] accel_d;
    logic [39:0] freq_d;
    logic tick;
    logic run;

    assign run = (st_q == ST_ALIGN) || (st_q == ST_RAMP);

    tick_divider #(
        .CYCLES(TICK_LEN)
    ) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(run),
        .tick_q(tick)
    );

    // Align, then ramp on each tick, then hold closed loop until stop.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        accel_d = accel_q;
        freq_d = freq_q;
        case (st_q)
            ST_IDLE: begin
                cnt_d = 32'h0000_0000;
                freq_d = 40'h00_0000_0000;
                if (start_req) begin
                    st_d = ST_ALIGN;
                end
            end
            ST_ALIGN: begin
                if (tick) begin
                    cnt_d = cnt_q + 32'h0000_0001;
                    if (cnt_q == align_len - 32'h0000_0001) begin
                        st_d = ST_RAMP;
                        accel_d = a1_val;
                        cnt_d = 32'h0000_0000;
                    end
                end
            end
            ST_RAMP: begin
                if (freq_q >= thr_val) begin
                    st_d = ST_CLOSED;
                end else if (tick) begin
                    freq_d = freq_q + 40'(accel_q);
                    accel_d = accel_q + a2_val;
                end
            end
            ST_CLOSED: begin
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        if (!start_req) begin
            st_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= ST_IDLE;
            cnt_q <= 32'h0000_0000;
            accel_q <= 32'h0000_0000;
            freq_q <= 40'h00_0000_0000;
            aligning_q <= 1'b0;
            open_loop_q <= 1'b0;
            closed_loop_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            accel_q <= accel_d;
            freq_q <= freq_d;
            aligning_q <= (st_d == ST_ALIGN);
            open_loop_q <= (st_d == ST_RAMP);
            closed_loop_q <= (st_d == ST_CLOSED);
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_ramping;
        st_q == ST_RAMP && tick && freq_q < thr_val && start_req;
    endsequence

    sequence s_align_done;
        st_q == ST_ALIGN && tick && start_req &&
            cnt_q == align_len - 32'h0000_0001;
    endsequence

    a_rsvd_reads_zero: assert property (
        reg_rdata_q[RSVD_BIT] == 1'b0)
        else $error("Reserved bit read back as one.");

    a_fast_a2_step: assert property (
        s_ramping ##0 (!range_slow && coef2 == 3'h0) |=>
        accel_q == $past(accel_q) + 32'd57000)
        else $error("Fast second-order step is wrong.");

    a_slow_a2_step: assert property (
        s_ramping ##0 (range_slow && coef2 == 3'h0) |=>
        accel_q == $past(accel_q) + 32'd220)
        else $error("Slow second-order step is wrong.");

    a_fast_a1_load: assert property (
        s_align_done ##0 (!range_slow && coef1 == 3'h7) |=>
        accel_q == 32'd300000 && open_loop_q)
        else $error("Fast first-order load is wrong.");

    a_slow_a1_load: assert property (
        s_align_done ##0 (range_slow && coef1 == 3'h7) |=>
        accel_q == 32'd19000 && open_loop_q)
        else $error("Slow first-order load is wrong.");

    a_range0_handover: assert property (
        (st_q == ST_RAMP && start_req && !thr_code[4] &&
         freq_q >= 40'(40'(thr_code) * 40'd800000000)) |=>
        closed_loop_q)
        else $error("Range 0 handover missed.");

    a_range1_handover: assert property (
        (st_q == ST_RAMP && start_req && thr_code == 5'h1F &&
         freq_q < 40'd203900000000) |=> !closed_loop_q)
        else $error("Range 1 handover came early.");

    a_align_bound: assert property (
        st_q == ST_ALIGN |-> cnt_q < align_len)
        else $error("Align ran past its duration.");

    a_reg_write: assert property (
        (reg_wr && reg_addr == 8'h93) |=>
        cfg_q == {1'b0, $past(reg_wdata[14:0])})
        else $error("Profile register write lost.");

    a_seq_order: assert property (
        $rose(closed_loop_q) |-> $past(st_q) == ST_RAMP)
        else $error("Closed loop entered without a ramp.");

endmodule // startup_profile_ctrl
`default_nettype wire

// >>> core/startup_profile_pkg.sv
`default_nettype none
package startup_profile_pkg;

    // ==========================================================
    // Register map and field layout
    // ==========================================================
    localparam logic [7:0] PROFILE_ADDR = 8'h93;
    localparam logic [15:0] PROFILE_RESET = 16'h0000;
    localparam int RSVD_BIT = 15;
    localparam int RANGE_BIT = 14;
    localparam int COEF2_LSB = 11;
    localparam int COEF1_LSB = 8;
    localparam int THR_LSB = 3;
    localparam int ALIGN_LSB = 0;

    // ==========================================================
    // Timing: the sequencer advances on a 1 ms tick
    // ==========================================================
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // ==========================================================
    // Decode tables, per 1 ms tick
    // ==========================================================
    // Frequency is held in nHz; first-order values are nHz added per
    // tick (Hz/s times 1e6); second-order values are nHz/tick added to
    // the first-order term per tick (Hz/s2 times 1e3).
    typedef logic [31:0] coef_table_t [0:7];
    localparam coef_table_t ACCEL2_FAST = '{32'd57000, 32'd29000,
        32'd14000, 32'd6900, 32'd3300, 32'd1600, 32'd660, 32'd0};
    localparam coef_table_t ACCEL2_SLOW = '{32'd220, 32'd110,
        32'd55, 32'd27, 32'd13, 32'd6, 32'd3, 32'd0};
    localparam coef_table_t ACCEL1_FAST = '{32'd76000000, 32'd38000000,
        32'd19000000, 32'd9200000, 32'd4500000, 32'd2100000,
        32'd900000, 32'd300000};
    localparam coef_table_t ACCEL1_SLOW = '{32'd4800000, 32'd2400000,
        32'd1200000, 32'd580000, 32'd290000, 32'd130000,
        32'd60000, 32'd19000};
    // Align durations in ticks (ms).
    localparam coef_table_t ALIGN_TICKS = '{32'd5300, 32'd2700,
        32'd1300, 32'd670, 32'd330, 32'd160, 32'd80, 32'd40};

    // Handover threshold steps in nHz.
    localparam logic [39:0] THR0_STEP = 40'd800000000;
    localparam logic [39:0] THR1_STEP = 40'd12800000000;
    localparam logic [39:0] THR1_BASE = 40'd11900000000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ALIGN,
        ST_RAMP,
        ST_CLOSED
    } seq_state_t;

endpackage
`default_nettype wire

// >>> core/tick_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int CYCLES = 125000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic run,
    output logic tick_q
);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_d;

    // Counts while running and restarts from zero when stopped.
    always_comb begin
        cnt_d = 32'h0000_0000;
        tick_d = 1'b0;
        if (run) begin
            if (cnt_q == 32'(CYCLES - 1)) begin
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

endmodule // tick_divider
`default_nettype wire

// >>> verif/profile_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host model for the register strobe interface
// ==========================================================
module profile_host (
    input wire logic clk,
    input wire logic [15:0] reg_rdata_q,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata
);
    // The bus starts idle with both strobes low.
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_wdata = 16'h0000;
    end

    // One write strobe held across exactly one rising edge.
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(negedge clk);
        reg_wr = 1'h0;
        reg_wdata = ~d; // Released data must not look valid.
    endtask

    // One read strobe; the registered answer is taken a cycle later.
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'h1;
        @(negedge clk);
        reg_rd = 1'h0;
        @(negedge clk);
        d = reg_rdata_q;
    endtask
endmodule // profile_host
`default_nettype wire

// >>> verif/startup_profile_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module startup_profile_ctrl_bench;
    import startup_profile_pkg::*;
    localparam int TL = 4;
    localparam logic [39:0] A1 [0:15] = '{40'h487AB00, 40'h243D580,
        40'h121EAC0, 40'h8C6180, 40'h44AA20, 40'h200B20, 40'hDBBA0,
        40'h493E0, 40'h493E00, 40'h249F00, 40'h124F80, 40'h8D9A0,
        40'h46CD0, 40'h1FBD0, 40'hEA60, 40'h4A38};
    localparam logic [39:0] A2 [0:15] = '{40'hDEA8, 40'h7148, 40'h36B0,
        40'h1AF4, 40'hCE4, 40'h640, 40'h294, 40'h0, 40'hDC, 40'h6E,
        40'h37, 40'h1B, 40'hD, 40'h6, 40'h3, 40'h0};
    localparam int AT [0:7] = '{5300, 2700, 1300, 670, 330, 160, 80, 40};
    localparam logic [39:0] TH [0:3] = '{40'h2FAF0800, 40'h2CB417800,
        40'h2C54B9700, 40'h5C03C1700};
    localparam logic [4:0] TC [0:3] = '{5'h01, 5'h0F, 5'h10, 5'h11};
    logic clk, sys_rst, start_req, reg_wr, reg_rd;
    logic aligning_q, open_loop_q, closed_loop_q;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata_q, rd;
    logic [39:0] freq_q, f1, f2;
    int fail_count, checks_done, n;

    startup_profile_ctrl #(.TICK_LEN(TL)) u_startup_profile_ctrl (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .start_req(start_req),
        .aligning_q(aligning_q), .open_loop_q(open_loop_q),
        .closed_loop_q(closed_loop_q), .freq_q(freq_q));
    profile_host u_profile_host (.clk(clk), .reg_rdata_q(reg_rdata_q),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata));

    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [39:0] seen,
        input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Programs the register, starts, times the align phase, takes two ramp steps.
    task automatic run(input logic [15:0] cfg);
        u_profile_host.wr_reg(PROFILE_ADDR, cfg);
        start_req = 1'h1;
        @(negedge clk);
        check("align start", 40'(aligning_q), 40'h1);
        n = 1;
        while (aligning_q === 1'h1 && n < 30000) begin
            @(negedge clk);
            n++;
        end
        check("align time", 40'(n >= AT[cfg[2:0]] * TL &&
            n <= AT[cfg[2:0]] * TL + TL + 1), 40'h1);
        check("ramp phase", 40'(open_loop_q), 40'h1);
        n = 0;
        while (freq_q === 40'h0 && n < 3 * TL) begin
            @(negedge clk);
            n++;
        end
        f1 = freq_q;
        while (freq_q === f1 && n < 6 * TL) begin
            @(negedge clk);
            n++;
        end
        f2 = freq_q;
    endtask

    // Drops the start request and expects everything back at rest.
    task automatic halt();
        start_req = 1'h0;
        repeat (3) @(negedge clk);
        // The phase flags and the frequency are checked apart, so no bit is lost.
        check("abort phase", {37'h0, aligning_q, open_loop_q, closed_loop_q}, 40'h0);
        check("abort freq", freq_q, 40'h0);
    endtask

    // Free-running 125 MHz clock.
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    // Watchdog sized well above the expected run of about 50k cycles.
    initial begin
        #700000;
        fail_count++;
        stop_test();
    end

    // Main sequence of register and start-up tests.
    initial begin
        sys_rst = 1'h1;
        start_req = 1'h0;
        fail_count = 0;
        checks_done = 0;
        repeat (10) @(negedge clk);
        sys_rst = 1'h0;
        u_profile_host.rd_reg(PROFILE_ADDR, rd);
        check("reset value", 40'(rd), 40'h0);
        u_profile_host.wr_reg(PROFILE_ADDR, 16'hFFFF);
        u_profile_host.rd_reg(PROFILE_ADDR, rd);
        check("reserved bit", 40'(rd), 40'h7FFF);
        u_profile_host.rd_reg(8'h92, rd);
        check("unmapped read", 40'(rd), 40'h0);
        halt();
        // Every coefficient code in both ranges, every align code.
        for (int i = 0; i < 16; i++) begin
            run({1'h0, i[3], i[2:0], i[2:0], 5'h1F,
                i[3] ? 3'h7 : i[2:0]});
            check("first order", f1, A1[i]);
            check("second order", f2, A1[i] + A1[i] + A2[i]);
            halt();
        end
        // Handover points in both threshold ranges.
        for (int i = 0; i < 4; i++) begin
            run({8'h38, TC[i], 3'h7});
            n = 0;
            while (closed_loop_q !== 1'h1 && n < 20000) begin
                @(negedge clk);
                n++;
            end
            check("closed loop", 40'(closed_loop_q), 40'h1);
            check("handover", 40'(freq_q >= TH[i] &&
                freq_q < TH[i] + A1[0]), 40'h1);
            halt();
        end
        stop_test();
    end
endmodule // startup_profile_ctrl_bench
`default_nettype wire
